// *** core/evr_params.svh ***
`ifndef EVR_PARAMS_SVH
`define EVR_PARAMS_SVH
// register locations, word-addressed as printed
`define EVR_ADDR_BEMF_Q 12'h724
`define EVR_ADDR_BEMF_D 12'h726
`define EVR_ADDR_SPEED 12'h734
`define EVR_ADDR_ANGLE 12'h736
// reset value of every readback word
`define EVR_RST_WORD 32'h0000_0000
// fractional bits of the fixed-point scaling
`define EVR_FRAC_BITS 27
`endif

// *** core/evr_pkg.sv ***
package evr_pkg;
  // one estimator sample, all four words taken together
  typedef struct packed {
    logic [31:0] bemf_q_estimate;
    logic [31:0] bemf_d_estimate;
    logic [31:0] rotor_speed_estimate;
    logic [31:0] rotor_angle_estimate;
  } evr_sample_t;
  // host read request
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
  } evr_rd_req_t;
endpackage : evr_pkg

// *** core/evr_readback.sv ***
`timescale 1ns/10ps
`include "evr_params.svh"

module evr_readback (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  // estimator sample from the algorithm, same clock
  input wire evr_pkg::evr_sample_t I_SAMPLE,
  input wire logic I_SAMPLE_VALID,
  // host read port
  input wire evr_pkg::evr_rd_req_t I_RD_REQ,
  output evr_pkg::evr_rd_req_t O_RD_ECHO,
  output logic [31:0] O_RD_DATA,
  output logic O_RD_VALID,
  output logic O_RD_HIT
);

  // ----------------------------------------------------------------
  // sample holding registers
  // ----------------------------------------------------------------
  evr_pkg::evr_sample_t held;
  evr_pkg::evr_sample_t next_held;

  // all four words load in one edge, so a read sees one whole sample
  // loads need no host traffic at all, the bank runs stand-alone
  always_comb begin
    next_held = held;
    if (I_SAMPLE_VALID) begin
      next_held = I_SAMPLE;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      held <= {4{`EVR_RST_WORD}};
    end else begin
      held <= next_held;
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [31:0] next_rd_data;
  logic next_rd_hit;

  // no write path exists, so the words stay read-only by construction
  always_comb begin
    next_rd_data = `EVR_RST_WORD;
    next_rd_hit = 1'b1;
    if (I_RD_REQ.addr == `EVR_ADDR_BEMF_Q) begin
      next_rd_data = held.bemf_q_estimate;
    end else if (I_RD_REQ.addr == `EVR_ADDR_BEMF_D) begin
      next_rd_data = held.bemf_d_estimate;
    end else if (I_RD_REQ.addr == `EVR_ADDR_SPEED) begin
      next_rd_data = held.rotor_speed_estimate;
    end else if (I_RD_REQ.addr == `EVR_ADDR_ANGLE) begin
      next_rd_data = held.rotor_angle_estimate;
    end else begin
      next_rd_hit = 1'b0; // unmapped reads answer zero
    end
    if (!I_RD_REQ.valid) begin
      next_rd_data = `EVR_RST_WORD;
      next_rd_hit = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RD_DATA <= `EVR_RST_WORD;
      O_RD_HIT <= 1'b0;
      O_RD_VALID <= 1'b0;
      O_RD_ECHO <= '0;
    end else begin
      O_RD_DATA <= next_rd_data;
      O_RD_HIT <= next_rd_hit;
      O_RD_VALID <= I_RD_REQ.valid;
      O_RD_ECHO <= I_RD_REQ;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_Q_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_RD_REQ.valid && I_RD_REQ.addr == `EVR_ADDR_BEMF_Q)
      |=> (O_RD_VALID && O_RD_HIT && O_RD_DATA == $past(held.bemf_q_estimate)))
    else $error("q back-emf read wrong");
  AST_D_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_RD_REQ.valid && I_RD_REQ.addr == `EVR_ADDR_BEMF_D)
      |=> (O_RD_HIT && O_RD_DATA == $past(held.bemf_d_estimate)))
    else $error("d back-emf read wrong");
  AST_SPEED_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_RD_REQ.valid && I_RD_REQ.addr == `EVR_ADDR_SPEED)
      |=> (O_RD_HIT && O_RD_DATA == $past(held.rotor_speed_estimate)))
    else $error("speed read wrong");
  AST_ANGLE_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_RD_REQ.valid && I_RD_REQ.addr == `EVR_ADDR_ANGLE)
      |=> (O_RD_HIT && O_RD_DATA == $past(held.rotor_angle_estimate)))
    else $error("angle read wrong");
  // a load in the first cycle after release is legal, so only the release edge is checked
  AST_ZERO_UNTIL_LOAD: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    $rose(I_NRST) |-> held == '0)
    else $error("word not zero after reset");
  AST_WHOLE_UPDATE: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    I_SAMPLE_VALID |=> held == $past(I_SAMPLE))
    else $error("sample not loaded whole");
  AST_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    !I_SAMPLE_VALID |=> $stable(held))
    else $error("words changed without update");
  AST_MISS: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_RD_REQ.valid && !next_rd_hit) |=> (O_RD_VALID && !O_RD_HIT && O_RD_DATA == 32'h0000_0000))
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // read port framing checks
  // ----------------------------------------------------------------
  // the echo lets a host pair each answer with its request
  AST_ECHO: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    1'b1 |=> (O_RD_ECHO == $past(I_RD_REQ) && O_RD_VALID == $past(I_RD_REQ.valid)))
    else $error("read echo does not follow request");
  // idle cycles must leave the data lines at zero, no stale word leaks out
  AST_NO_REQ_QUIET: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    !I_RD_REQ.valid |=> (!O_RD_VALID && !O_RD_HIT && O_RD_DATA == 32'h0000_0000))
    else $error("output active without request");
  // a hit is only meaningful together with its valid strobe
  AST_HIT_NEEDS_VALID: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    O_RD_HIT |-> O_RD_VALID)
    else $error("hit without valid");
  // the algorithm keeps updating with the host silent
  AST_STANDALONE: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_SAMPLE_VALID && !I_RD_REQ.valid) |=> held == $past(I_SAMPLE))
    else $error("sample lost without host traffic");

  // ----------------------------------------------------------------
  // per-word view for the checks
  // ----------------------------------------------------------------
  // word order follows the sample struct: q, d, speed, angle
  logic [31:0] word_view [4];
  logic [11:0] word_addr [4];

  // word locations in the same order as the view
  assign word_addr[0] = `EVR_ADDR_BEMF_Q;
  assign word_addr[1] = `EVR_ADDR_BEMF_D;
  assign word_addr[2] = `EVR_ADDR_SPEED;
  assign word_addr[3] = `EVR_ADDR_ANGLE;

  // one slice per word; the struct is msb first, so word 0 sits on top
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_word
      assign word_view[gi] = held[(3 - gi) * 32 +: 32];

      // each word comes out of reset at zero
      AST_WORD_RESET: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        $rose(I_NRST) |-> word_view[gi] == `EVR_RST_WORD)
        else $error("word not zero after reset");

      // a load moves the whole 32-bit word, never a half
      AST_WORD_LOAD: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        I_SAMPLE_VALID |=> word_view[gi] == $past(I_SAMPLE[(3 - gi) * 32 +: 32]))
        else $error("word not loaded whole");

      // without a load the word keeps its value
      AST_WORD_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        !I_SAMPLE_VALID |=> $stable(word_view[gi]))
        else $error("word changed without load");

      // a read of this location returns the word as it stood at the taking edge
      AST_WORD_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        (I_RD_REQ.valid && I_RD_REQ.addr == word_addr[gi])
          |=> (O_RD_VALID && O_RD_HIT && O_RD_DATA == $past(word_view[gi])))
        else $error("word read wrong");
    end
  endgenerate

  // ----------------------------------------------------------------
  // limitations
  // ----------------------------------------------------------------
  // the bank is read-only: the words change only through the sample port,
  // so no host access can tear a word; the price is one cycle of read latency
  // because data is registered before it leaves the block.
  // reads in the load cycle return the old word, which keeps the decode
  // independent of the load path and the output a clean flip-flop.

endmodule : evr_readback

// *** test/estimator_variable_readback_tb.sv ***
`timescale 1ns/10ps
`include "evr_params.svh"
module estimator_variable_readback_tb;
  logic clk = 1'b0, nrst = 1'b0, sv = 1'b0, go = 1'b0, rvalid, hit, ehit = 1'b0, q;
  logic [11:0] addr = 12'h000;
  logic [31:0] seed = 32'h0000_daa6, rdata, ed = 32'h0000_0000;
  logic [31:0] mdl [4] = '{default: 32'h0000_0000};
  logic [11:0] amap [5] = '{`EVR_ADDR_BEMF_Q, `EVR_ADDR_BEMF_D, `EVR_ADDR_SPEED,
    `EVR_ADDR_ANGLE, 12'h725};
  evr_pkg::evr_sample_t smp = '0;
  evr_pkg::evr_rd_req_t req, echo, ereq = '0;
  int error_cnt = 0, total_checks = 0, k, ai;
  always #2.5 clk = ~clk;
  evr_host host (.i_go(go), .i_addr(addr), .o_req(req));
  evr_readback dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_SAMPLE(smp), .I_SAMPLE_VALID(sv),
    .I_RD_REQ(req), .O_RD_ECHO(echo), .O_RD_DATA(rdata), .O_RD_VALID(rvalid), .O_RD_HIT(hit));
  // xorshift keeps the run repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // random loads and back-to-back reads, with a reset in mid-run
  initial begin
    repeat (3) @(negedge clk);
    for (k = 0; k < 300; k++) begin
      chk(rdata, ed);
      chk({30'h0, rvalid, hit}, {30'h0, ereq.valid, ehit});
      chk({19'h0, echo}, {19'h0, ereq});
      q = k >= 150 && k <= 153;
      nrst = !(k >= 150 && k < 153);
      seed = xs(seed);
      ai = seed[4:2] % 5;
      go = seed[0] && !q;
      sv = seed[1] && !q;
      addr = q ? 12'h000 : amap[ai];
      smp = {seed, ~seed, xs(seed), seed ^ 32'h5a5a_a5a5};
      ereq = '{valid: go, addr: addr};
      ehit = go && ai < 4;
      ed = ehit ? mdl[ai] : 32'h0000_0000;
      // a read in the load cycle still sees the old word
      if (sv) mdl = '{smp[127:96], smp[95:64], smp[63:32], smp[31:0]};
      if (!nrst) mdl = '{default: 32'h0000_0000};
      @(negedge clk);
    end
    $display("test random readback done");
    complete_run();
  end
endmodule : estimator_variable_readback_tb

// *** test/evr_host.sv ***
`timescale 1ns/10ps
// host model: one read request a cycle, driven on the falling edge
// reads only; the bank has no write path, so no setup writes are needed
module evr_host (
  // request fields
  input wire logic i_go,
  input wire logic [11:0] i_addr,
  // to the read port
  output evr_pkg::evr_rd_req_t o_req
);
  assign o_req = '{valid: i_go, addr: i_addr};
endmodule : evr_host
